//--- hw/lsc_defines.svh
/*
  Offsets, field positions, reset values and codes for the link status and
  counter register bank. Assumes 8-bit register addresses and 16-bit data.
*/
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

// register addresses, word addressed
`define LSC_ADDR_PROC_STATUS   8'h54
`define LSC_ADDR_RX_COUNT      8'h55
`define LSC_ADDR_CRC_COUNT     8'h56
`define LSC_ADDR_FMT_COUNT     8'h57
`define LSC_ADDR_LINK_STATE    8'h58
`define LSC_ADDR_TX_COUNT      8'h59
`define LSC_ADDR_CMD0          8'h64
`define LSC_ADDR_CMD1          8'h65
`define LSC_ADDR_IRQ_STATUS    8'h70
`define LSC_ADDR_IRQ_MASK      8'h71
`define LSC_ADDR_CONTROL       8'h72

// widths
`define LSC_AW                 8
`define LSC_DW                 16
`define LSC_IRQ_W              5
`define LSC_NUM_RX_CNT         3

// processor status word fields
`define LSC_STS_NO_MEM         13
`define LSC_STS_BAD_ADDR       14
`define LSC_STS_STACK_OVF      15

// command register 0 read-only bit
`define LSC_CMD0_RUN_BIT       15

// control register fields (write pulses)
`define LSC_CTL_FAULT_RST      0
`define LSC_CTL_WARN_RST       1

// interrupt status fields
`define LSC_IRQ_LOAD_FAIL      0
`define LSC_IRQ_CRC            1
`define LSC_IRQ_FMT            2
`define LSC_IRQ_RX_WRAP        3
`define LSC_IRQ_STOP_ALL       4

// link state word codes
`define LSC_LS_WAIT_REQ        8'h01
`define LSC_LS_DOWNLOAD        8'h02
`define LSC_LS_EXCHANGE        8'h03
`define LSC_LS_LOOPBACK        8'h06
`define LSC_SYNC_YES           8'h01
`define LSC_SYNC_NO            8'h02

// reset value, count step and wrap limit
`define LSC_ZERO16             16'h0000
`define LSC_ONE16              16'h0001
`define LSC_MAX16              16'hffff

`endif

//--- hw/lsc_pkg.sv
/*
  Types shared by the link status and counter register bank.
  Assumes lsc_defines.svh is on the include path.
*/
`include "lsc_defines.svh"

package lsc_pkg;

  // link state reported by the link engine, encoded as the low byte
  typedef enum logic [7:0] {
    LSC_WAIT_REQ = `LSC_LS_WAIT_REQ,
    LSC_DOWNLOAD = `LSC_LS_DOWNLOAD,
    LSC_EXCHANGE = `LSC_LS_EXCHANGE,
    LSC_LOOPBACK = `LSC_LS_LOOPBACK
  } lsc_link_state_t;

  // one-cycle event pulses from the link engine
  typedef struct packed {
    logic rxMsg;
    logic crcErr;
    logic fmtErr;
    logic txPortA;
    logic txPortB;
    logic loadNoMem;
    logic loadBadAddr;
    logic loadStackOvf;
  } lsc_link_evt_t;

  // current link view, levels
  typedef struct packed {
    lsc_link_state_t state;
    logic            synced;
  } lsc_link_view_t;

  // command message handed to the link once per scan
  typedef struct packed {
    logic [`LSC_DW-1:0] word0;
    logic [`LSC_DW-1:0] word1;
  } lsc_cmd_msg_t;

endpackage

//--- hw/lsc_link_status_counters.sv
/*
  Link status and statistics register bank with command forwarding.
  Holds the drive_side_processor status word, message counters, the link
  state word and two command registers forwarded once per regulator scan.
  Assumes: all inputs synchronous to core_clk, event inputs are one-cycle
  pulses, the link engine drives link view and events.
*/
// The implementer's own choice: the address-and-strobe port.
// Behaviour
// RQ1 - status bit 13 sets when processor lacks memory for image load
// RQ2 - status bit 14 sets when processor reports invalid image load address
// RQ3 - status bit 15 sets when image load would overrun processor stack
// RQ4 - after load failure both ends keep retrying the image load
// RQ5 - receive count is 16 bits and wraps after its maximum
// RQ6 - read-only counter of messages received with crc errors
// RQ7 - read-only counter of messages received with format errors
// RQ8 - link state word: state in low byte, sync in high byte
// RQ9 - low byte 01 hex means waiting for image request
// RQ10 - low byte 02 hex means image download in progress
// RQ11 - low byte 03 hex means normal data exchange
// RQ12 - low byte 06 hex means external loopback test running
// RQ13 - high byte 01 hex synchronized, 02 hex unsynchronized
// RQ14 - read-only count of messages transmitted on both link ports
// RQ15 - command registers sent to processor once at each scan end
// RQ16 - command bits only request; command 0 bit 15 is read-only
// RQ17 - command register contents discarded on stop-all
// RQ18 - status error bits latch until fault or warning reset
// RQ19 - counters step by one per message and start at zero
`timescale 1ns/1ns
`include "lsc_defines.svh"

module lsc_link_status_counters (
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire logic                    clkEn,
  input  wire logic [`LSC_AW-1:0]      regAddr,
  input  wire logic [`LSC_DW-1:0]      regWrData,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [`LSC_DW-1:0]      regRdData,
  input  wire lsc_pkg::lsc_link_evt_t  linkEvt,
  input  wire lsc_pkg::lsc_link_view_t linkView,
  input  wire logic                    runStatus,
  input  wire logic                    scanEnd,
  input  wire logic                    stopAll,
  output lsc_pkg::lsc_cmd_msg_t        cmdMsg,
  output logic                         cmdValid,
  output logic                         reloadReq,
  output logic                         irq
);

  // address decode shared by the write paths; the read mux uses a case
  function automatic logic isAddr(input logic [`LSC_AW-1:0] a,
                                  input logic [`LSC_AW-1:0] ref_a);
    isAddr = (a == ref_a);
  endfunction

  logic [`LSC_DW-1:0]    procStatus;
  logic [`LSC_DW-1:0]    rxCnt [`LSC_NUM_RX_CNT];
  logic [`LSC_DW-1:0]    txCnt;
  logic [`LSC_DW-1:0]    cmd0;
  logic [`LSC_DW-1:0]    cmd1;
  logic [`LSC_IRQ_W-1:0] irqStatus;
  logic [`LSC_IRQ_W-1:0] irqMask;
  logic [`LSC_IRQ_W-1:0] irqEvt;
  logic [`LSC_NUM_RX_CNT-1:0] cntInc;
  logic [`LSC_DW-1:0]    linkWord;
  logic [`LSC_DW-1:0]    next_rdData;
  logic [`LSC_DW-1:0]    statusSet;
  logic                  wrCtl;
  logic                  statusClr;
  logic                  loadFail;

  // control write strobe decoded once
  assign wrCtl = regWr && isAddr(regAddr, `LSC_ADDR_CONTROL);

  // either reset pulse clears the latched status word
  assign statusClr = wrCtl && (regWrData[`LSC_CTL_FAULT_RST] ||
                               regWrData[`LSC_CTL_WARN_RST]);

  // load failure flags reported by the processor
  always_comb begin
    statusSet = `LSC_ZERO16;
    // RQ1 no-memory flag
    statusSet[`LSC_STS_NO_MEM] = linkEvt.loadNoMem;
    // RQ2 bad-address flag
    statusSet[`LSC_STS_BAD_ADDR] = linkEvt.loadBadAddr;
    // RQ3 stack overrun flag
    statusSet[`LSC_STS_STACK_OVF] = linkEvt.loadStackOvf;
  end

  assign loadFail = linkEvt.loadNoMem || linkEvt.loadBadAddr ||
                    linkEvt.loadStackOvf;

  // processor status word; a new report wins over a reset in one cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      procStatus <= `LSC_ZERO16;
    end else if (clkEn) begin
      // RQ18 latch until reset
      procStatus <= (statusClr ? `LSC_ZERO16 : procStatus) | statusSet;
    end
  end

  // retry request back to the link engine after every failed load
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reloadReq <= 1'b0;
    end else if (clkEn) begin
      // RQ4 keep retrying load
      reloadReq <= loadFail;
    end
  end

  // receive, crc and format counters share one structure
  assign cntInc = {linkEvt.fmtErr, linkEvt.crcErr, linkEvt.rxMsg};

  generate
    for (genvar g = 0; g < `LSC_NUM_RX_CNT; g++) begin : gRxCnt
      // RQ5 16-bit wrapping count; RQ6 crc count; RQ7 format count
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          // RQ19 start from zero
          rxCnt[g] <= `LSC_ZERO16;
        end else if (clkEn && cntInc[g]) begin
          // RQ19 step by one
          rxCnt[g] <= rxCnt[g] + `LSC_ONE16;
        end
      end
    end
  endgenerate

  // transmit count covers both ports, so two in one cycle adds two
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txCnt <= `LSC_ZERO16;
    end else if (clkEn) begin
      // RQ14 both ports counted
      txCnt <= txCnt + {{(`LSC_DW-1){1'b0}}, linkEvt.txPortA}
                     + {{(`LSC_DW-1){1'b0}}, linkEvt.txPortB};
    end
  end

  // link state word built from the live link view
  always_comb begin
    // RQ8 state low, sync high
    linkWord[7:0] = linkView.state;
    // RQ9 RQ10 RQ11 RQ12 enum carries the codes
    // RQ13 sync byte encoding
    linkWord[15:8] = linkView.synced ? `LSC_SYNC_YES : `LSC_SYNC_NO;
  end

  // command registers; stop-all outranks a write in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd0 <= `LSC_ZERO16;
      cmd1 <= `LSC_ZERO16;
    end else if (clkEn) begin
      if (stopAll) begin
        // RQ17 discard on stop-all
        cmd0 <= `LSC_ZERO16;
        cmd1 <= `LSC_ZERO16;
      end else if (regWr) begin
        if (isAddr(regAddr, `LSC_ADDR_CMD0)) begin
          // RQ16 top bit not writable
          cmd0 <= regWrData & ~(`LSC_ONE16 << `LSC_CMD0_RUN_BIT);
        end
        if (isAddr(regAddr, `LSC_ADDR_CMD1)) begin
          cmd1 <= regWrData;
        end
      end
    end
  end

  // forward commands once per scan; data held until the next scan end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmdMsg   <= '0;
      cmdValid <= 1'b0;
    end else if (clkEn) begin
      // RQ15 one send per scan
      cmdValid <= scanEnd;
      if (scanEnd) begin
        cmdMsg.word0 <= cmd0;
        cmdMsg.word1 <= cmd1;
      end
    end
  end

  // interrupt events
  always_comb begin
    irqEvt = '0;
    irqEvt[`LSC_IRQ_LOAD_FAIL] = loadFail;
    irqEvt[`LSC_IRQ_CRC]       = linkEvt.crcErr;
    irqEvt[`LSC_IRQ_FMT]       = linkEvt.fmtErr;
    irqEvt[`LSC_IRQ_RX_WRAP]   = linkEvt.rxMsg && (rxCnt[0] == `LSC_MAX16);
    irqEvt[`LSC_IRQ_STOP_ALL]  = stopAll;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= '0;
    end else if (clkEn) begin
      if (regWr && isAddr(regAddr, `LSC_ADDR_IRQ_STATUS)) begin
        irqStatus <= (irqStatus & ~regWrData[`LSC_IRQ_W-1:0]) | irqEvt;
      end else begin
        irqStatus <= irqStatus | irqEvt;
      end
    end
  end

  // mask register, all sources off after reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irqMask <= '0;
    end else if (clkEn && regWr && isAddr(regAddr, `LSC_ADDR_IRQ_MASK)) begin
      irqMask <= regWrData[`LSC_IRQ_W-1:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

  // read mux; unmapped and write-only addresses read zero
  always_comb begin
    case (regAddr)
      `LSC_ADDR_PROC_STATUS: next_rdData = procStatus;
      `LSC_ADDR_RX_COUNT:    next_rdData = rxCnt[0];
      `LSC_ADDR_CRC_COUNT:   next_rdData = rxCnt[1];
      `LSC_ADDR_FMT_COUNT:   next_rdData = rxCnt[2];
      `LSC_ADDR_LINK_STATE:  next_rdData = linkWord;
      `LSC_ADDR_TX_COUNT:    next_rdData = txCnt;
      // RQ16 top bit shows run status
      `LSC_ADDR_CMD0: begin
        next_rdData = cmd0;
        next_rdData[`LSC_CMD0_RUN_BIT] = runStatus;
      end
      `LSC_ADDR_CMD1:        next_rdData = cmd1;
      `LSC_ADDR_IRQ_STATUS:  next_rdData = {{(`LSC_DW-`LSC_IRQ_W){1'b0}}, irqStatus};
      `LSC_ADDR_IRQ_MASK:    next_rdData = {{(`LSC_DW-`LSC_IRQ_W){1'b0}}, irqMask};
      default:               next_rdData = `LSC_ZERO16;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= `LSC_ZERO16;
    end else if (clkEn) begin
      regRdData <= regRd ? next_rdData : `LSC_ZERO16;
    end
  end

endmodule // lsc_link_status_counters

//--- dv/lsc_status_chk.sv
/*
  Assertion checker for the link status and counter bank.
  Assumes it is bound to lsc_link_status_counters, one clock domain.
*/
`timescale 1ns/1ns
`include "lsc_defines.svh"
module lsc_status_chk (
  input wire logic                    core_clk,
  input wire logic                    rstn,
  input wire logic                    clkEn,
  input wire logic [`LSC_AW-1:0]      regAddr,
  input wire logic                    regRd,
  input wire logic [`LSC_DW-1:0]      regRdData,
  input wire lsc_pkg::lsc_link_evt_t  linkEvt,
  input wire lsc_pkg::lsc_link_view_t linkView,
  input wire logic                    scanEnd,
  input wire lsc_pkg::lsc_cmd_msg_t   cmdMsg,
  input wire logic                    cmdValid,
  input wire logic                    reloadReq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // read data only in the cycle after a read
  property p_rd_idle; ($past(clkEn) && !$past(regRd)) |-> regRdData == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_cmd_go; (scanEnd && clkEn) |=> cmdValid; endproperty
  a_cmd_go: assert property (p_cmd_go) else $error("command not sent");
  property p_cmd_src; cmdValid |-> $past(scanEnd) || !$past(clkEn); endproperty
  a_cmd_src: assert property (p_cmd_src) else $error("stray command send");
  property p_cmd_ro; cmdMsg.word0[15] == 1'b0; endproperty
  a_cmd_ro: assert property (p_cmd_ro) else $error("read-only bit sent");
  // between scans the sent words stay put, even over a stop-all
  property p_cmd_hold; !$past(scanEnd) |-> $stable(cmdMsg); endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command moved");
  property p_reload; (clkEn && |linkEvt[2:0]) |=> reloadReq; endproperty
  a_reload: assert property (p_reload) else $error("no retry request");
  property p_ls; (regRd && clkEn && regAddr == 8'h58) |=>
    regRdData == {$past(linkView.synced) ? 8'h01 : 8'h02, $past(linkView.state)}; endproperty
  a_ls: assert property (p_ls) else $error("link state word wrong");
  property p_sts; (regRd && clkEn && regAddr == 8'h54) |=> regRdData[12:0] == 13'h0000; endproperty
  a_sts: assert property (p_sts) else $error("status low bits set");
  c_scan: cover property (scanEnd && clkEn);
  c_load: cover property (reloadReq);
  c_ls: cover property (regRd && regAddr == 8'h58);
endmodule // lsc_status_chk

bind lsc_link_status_counters lsc_status_chk lsc_status_chk_inst (.core_clk, .rstn, .clkEn,
  .regAddr, .regRd, .regRdData, .linkEvt, .linkView, .scanEnd, .cmdMsg, .cmdValid, .reloadReq);

//--- dv/lsc_drive_proc.sv
/*
  Behavioural drive-side processor: reports link events and view.
  Assumes the bench asks for events; replies one cycle later.
*/
`timescale 1ns/1ns
module lsc_drive_proc (
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire lsc_pkg::lsc_link_evt_t  evtReq,
  input  wire lsc_pkg::lsc_link_view_t viewReq,
  input  wire logic                    reloadReq,
  output lsc_pkg::lsc_link_evt_t       linkEvt,
  output lsc_pkg::lsc_link_view_t      linkView,
  output logic [7:0]                   retries
);
  // event requests registered through as given, held as long as the bench holds them; view as levels
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      linkEvt <= '0;
      linkView <= '{state: lsc_pkg::LSC_WAIT_REQ, synced: 1'b0};
    end else begin
      linkEvt <= evtReq;
      linkView <= viewReq;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) retries <= 8'h00;
    else retries <= retries + 8'(reloadReq);
  end
endmodule // lsc_drive_proc

//--- dv/lsc_link_status_counters_tb_top.sv
/*
  Self-checking bench for the link status and counter bank.
  Assumes the design, package and partner are compiled first.
*/
`timescale 1ns/1ns
module lsc_link_status_counters_tb_top;
  logic core_clk, rstn, clkEn, regWr, regRd, runStatus, scanEnd, stopAll, cmdValid;
  logic reloadReq, irq;
  logic [7:0] regAddr, retries;
  logic [15:0] regWrData, regRdData, rxE, crcE, fmtE, txE, rxB, rnd;
  logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h03, 8'h06};
  lsc_pkg::lsc_link_evt_t evtReq, linkEvt;
  lsc_pkg::lsc_link_view_t viewReq, linkView;
  lsc_pkg::lsc_cmd_msg_t cmdMsg;
  integer fails, num_checks, seed, i;

  lsc_link_status_counters lsc_link_status_counters_inst (.core_clk, .rstn, .clkEn, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .linkEvt, .linkView, .runStatus, .scanEnd,
    .stopAll, .cmdMsg, .cmdValid, .reloadReq, .irq);
  lsc_drive_proc lsc_drive_proc_inst (.core_clk, .rstn, .evtReq, .viewReq, .reloadReq,
    .linkEvt, .linkView, .retries);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // expected counters follow what the design is fed
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) {rxE, crcE, fmtE, txE} <= '0;
    else if (clkEn) begin
      rxE <= rxE + linkEvt.rxMsg;
      crcE <= crcE + linkEvt.crcErr;
      fmtE <= fmtE + linkEvt.fmtErr;
      txE <= txE + linkEvt.txPortA + linkEvt.txPortB;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (e !== g) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk("regRdData", e, regRdData);
  endtask
  task automatic pulse(input logic [7:0] e);
    @(posedge core_clk);
    evtReq <= e;
    @(posedge core_clk);
    evtReq <= '0;
  endtask
  task automatic scan(input logic [31:0] e);
    @(posedge core_clk);
    scanEnd <= 1'b1;
    @(posedge core_clk);
    scanEnd <= 1'b0;
    #1 chk("cmdValid", 1, cmdValid);
    chk("cmdMsg", e, cmdMsg);
  endtask
  task automatic final_report;
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, well past the longest path
  initial begin
    #(80000 * 100);
    fails++;
    final_report;
  end
  // main sequence
  initial begin
    seed = 32'h0b80;
    {fails, num_checks} = '0;
    {regWr, regRd, runStatus, scanEnd, stopAll, rstn} = '0;
    {clkEn, regAddr, regWrData, evtReq} = 33'h100000000;
    viewReq = '{state: lsc_pkg::LSC_WAIT_REQ, synced: 1'b0};
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    for (i = 8'h54; i < 8'h5a; i++) if (i != 8'h58) rd(i[7:0], 16'h0000);
    for (i = 0; i < 8; i++) begin
      viewReq <= '{state: lsc_pkg::lsc_link_state_t'(codes[i/2]), synced: i[0]};
      rd(8'h58, {i[0] ? 8'h01 : 8'h02, codes[i/2]});
    end
    // random traffic, clock enable wandering too
    for (i = 0; i < 400; i++) begin
      @(posedge core_clk);
      evtReq <= 8'($random(seed)) & 8'hf8;
      clkEn <= ($random(seed) % 4) != 0;
    end
    pulse(8'h00);
    clkEn <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(8'h55, rxE);
    rd(8'h56, crcE);
    rd(8'h57, fmtE);
    rd(8'h59, txE);
    wr(8'h55, 16'h1234);
    rd(8'h55, rxE);
    // interrupt raised, masked, cleared
    wr(8'h70, 16'h001f);
    pulse(8'h40);
    #1 chk("irq", 0, irq);
    wr(8'h71, 16'h0002);
    #1 chk("irq", 1, irq);
    wr(8'h70, 16'h0002);
    #1 chk("irq", 0, irq);
    pulse(8'h04);
    rd(8'h54, 16'h2000);
    pulse(8'h02);
    rd(8'h54, 16'h6000);
    pulse(8'h01);
    rd(8'h54, 16'he000);
    chk("retries", 3, retries);
    wr(8'h72, 16'h0001);
    rd(8'h54, 16'h0000);
    pulse(8'h01);
    wr(8'h72, 16'h0002);
    rd(8'h54, 16'h0000);
    // receive counter taken once round its full range
    wr(8'h70, 16'h001f);
    rxB = rxE;
    @(posedge core_clk);
    evtReq <= 8'h80;
    repeat (65536) @(posedge core_clk);
    evtReq <= '0;
    repeat (2) @(posedge core_clk);
    rd(8'h55, rxB);
    rd(8'h70, 16'h0008);
    // command words go out at scan end, stop-all wipes them
    rnd = 16'($random(seed));
    runStatus <= 1'b1;
    wr(8'h64, 16'hffff);
    wr(8'h65, rnd);
    rd(8'h64, 16'hffff);
    scan({16'h7fff, rnd});
    @(posedge core_clk);
    stopAll <= 1'b1;
    @(posedge core_clk);
    stopAll <= 1'b0;
    scan(32'h00000000);
    rd(8'h64, 16'h8000);
    rd(8'h60, 16'h0000);
    final_report;
  end
endmodule // lsc_link_status_counters_tb_top
